// file: test/boot_sel_checker.sv
`default_nettype none
module boot_sel_checker (
    input wire logic       clock_i,
    input wire logic       reset_i,
    input wire logic       pcr_we_i,
    input wire logic [7:0] pcr_wdata_i,
    input wire logic       cpu_idle_i,
    input wire logic       update_done_i,
    input wire logic       fetch_internal_i,
    input wire logic       table_read_i,
    input wire logic       prog_mode_i,
    input wire logic       prog_opt_we_i,
    input wire logic       prog_flash_req_i,
    input wire logic       use_loader_flash_o,
    input wire logic       cpu_restart_o,
    input wire logic       update_active_o,
    input wire logic [7:0] pcr_rdata_o,
    input wire logic       table_internal_o,
    input wire logic       prog_flash_grant_o,
    input wire logic       prog_refused_o
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    wire quiet = !cpu_restart_o && !update_active_o && !pcr_we_i;
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    sequence s_hold4;
        cpu_restart_o [*4] ##1 !cpu_restart_o;
    endsequence
    property p_hold; $rose(cpu_restart_o) |-> s_hold4; endproperty
    a_hold: assert property (p_hold) else $error("restart length");
    property p_soft;
        pcr_we_i && pcr_wdata_i == 8'h83 && !cpu_restart_o
        && !update_active_o && !cpu_idle_i
        |=> cpu_restart_o && !use_loader_flash_o;
    endproperty
    a_soft: assert property (p_soft) else $error("soft restart");
    property p_ldr;
        pcr_rdata_o == 8'h03 && cpu_idle_i && quiet
        |=> use_loader_flash_o && cpu_restart_o;
    endproperty
    a_ldr: assert property (p_ldr) else $error("loader switch");
    property p_upd;
        pcr_rdata_o == 8'h01 && cpu_idle_i && quiet
        |=> update_active_o && !cpu_restart_o;
    endproperty
    a_upd: assert property (p_upd) else $error("update entry");
    property p_updh; update_active_o && !update_done_i |=> update_active_o;
    endproperty
    a_updh: assert property (p_updh) else $error("update hold");
    property p_int; table_read_i && fetch_internal_i |-> table_internal_o;
    endproperty
    a_int: assert property (p_int) else $error("internal read");
    property p_mode;
        prog_opt_we_i && !prog_mode_i |=> prog_refused_o && !prog_flash_grant_o;
    endproperty
    a_mode: assert property (p_mode) else $error("option refuse");
    property p_req;
        prog_flash_req_i && !prog_mode_i
        |=> !prog_flash_grant_o ##1 !prog_flash_grant_o;
    endproperty
    a_req: assert property (p_req) else $error("flash grant");
endmodule
bind boot_select boot_sel_checker chk (.*);
`default_nettype wire

// file: test/strap_model.sv
`default_nettype none
module strap_model (
    input  wire logic [2:0] press_i,
    output logic            pin_a_o,
    output logic            pin_b_o,
    output logic            pin_c_o
);
    // pulled up when the switch is open
    assign {pin_c_o, pin_b_o, pin_a_o} = ~press_i;
endmodule
`default_nettype wire

// file: test/tb.sv
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("Error %s exp %h got %h", n, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 0, reset_i = 1, pcr_we_i = 0, bank_we_i = 0;
    logic cpu_idle_i = 0, update_done_i = 0, fetch_internal_i = 0;
    logic table_read_i = 0, prog_mode_i = 0, prog_opt_we_i = 0;
    logic prog_opt_re_i = 0, prog_flash_req_i = 0, prog_erase_all_i = 0;
    logic [7:0] pcr_wdata_i = 0, bank_wdata_i = 0, prog_opt_wdata_i = 0;
    logic [2:0] press = 0;
    wire strap_pin_a_i, strap_pin_b_i, strap_pin_c_i;
    logic use_loader_flash_o, cpu_restart_o, update_active_o;
    logic table_internal_o, prog_flash_grant_o, prog_refused_o;
    logic [7:0] pcr_rdata_o, bank_select_o, prog_opt_rdata_o;
    int failures = 0, n_compared = 0;
    boot_select uut (.*);
    strap_model sm (.press_i(press), .pin_a_o(strap_pin_a_i),
                    .pin_b_o(strap_pin_b_i), .pin_c_o(strap_pin_c_i));
    initial begin
        forever #5 clock_i = ~clock_i;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic tick(int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic pcr(logic [7:0] v);
        @(posedge clock_i);
        pcr_we_i <= 1;
        pcr_wdata_i <= v;
        @(posedge clock_i);
        pcr_we_i <= 0;
        #1;
    endtask
    task automatic idle_pulse();
        @(posedge clock_i);
        cpu_idle_i <= 1;
        @(posedge clock_i);
        cpu_idle_i <= 0;
        #1;
    endtask
    // k = {opt write, opt read, erase all, flash request}
    task automatic prg(logic [3:0] k, logic [7:0] v);
        @(posedge clock_i);
        {prog_opt_we_i, prog_opt_re_i, prog_erase_all_i, prog_flash_req_i} <= k;
        prog_opt_wdata_i <= v;
        @(posedge clock_i);
        {prog_opt_we_i, prog_opt_re_i, prog_erase_all_i, prog_flash_req_i} <= 0;
        #1;
    endtask
    task automatic t_boot();
        press <= 3'h7;
        tick(3);
        `CHK("loader", 1'b0, use_loader_flash_o)
        `CHK("bank", 8'h00, bank_select_o)
        press <= 3'h0;
        $display("boot done");
    endtask
    task automatic t_soft();
        pcr(8'h83);
        `CHK("restart", 1'b1, cpu_restart_o)
        tick(4);
        `CHK("restart end", 1'b0, cpu_restart_o)
        pcr(8'h03);
        idle_pulse();
        `CHK("loader", 1'b1, use_loader_flash_o)
        `CHK("restart", 1'b1, cpu_restart_o)
        tick(5);
        pcr(8'h83);
        `CHK("main", 1'b0, use_loader_flash_o)
        tick(5);
        $display("restart done");
    endtask
    task automatic t_update();
        pcr(8'h01);
        idle_pulse();
        tick(3);
        `CHK("update", 1'b1, update_active_o)
        `CHK("loader", 1'b0, use_loader_flash_o)
        @(posedge clock_i);
        bank_we_i <= 1;
        bank_wdata_i <= 8'h01;
        @(posedge clock_i);
        bank_we_i <= 0;
        update_done_i <= 1;
        @(posedge clock_i);
        update_done_i <= 0;
        tick(1);
        `CHK("bank", 8'h01, bank_select_o)
        `CHK("update end", 1'b0, update_active_o)
        $display("update done");
    endtask
    task automatic t_prog();
        prog_mode_i <= 1;
        table_read_i <= 1;
        tick(1);
        `CHK("table", 1'b1, table_internal_o)
        prg(4'h8, 8'hfd);
        prg(4'h8, 8'hff);
        prg(4'h4, 0);
        `CHK("opt", 8'hfd, prog_opt_rdata_o)
        `CHK("table", 1'b0, table_internal_o)
        fetch_internal_i <= 1;
        tick(1);
        `CHK("table", 1'b1, table_internal_o)
        prg(4'h1, 0);
        `CHK("grant", 1'b1, prog_flash_grant_o)
        prg(4'h8, 8'hfe);
        prg(4'h1, 0);
        `CHK("refused", 1'b1, prog_refused_o)
        prg(4'h2, 0);
        prg(4'h4, 0);
        `CHK("opt", 8'hff, prog_opt_rdata_o)
        prog_mode_i <= 0;
        prg(4'h8, 8'h00);
        `CHK("refused", 1'b1, prog_refused_o)
        prg(4'h1, 0);
        `CHK("refused", 1'b1, prog_refused_o)
        $display("programmer done");
    endtask
    task automatic reboot(logic [7:0] opt, logic [2:0] keys);
        prog_mode_i <= 1;
        prg(4'h2, 0);
        prg(4'h8, opt);
        prog_mode_i <= 0;
        press <= keys;
        reset_i <= 1;
        tick(3);
        reset_i <= 0;
        tick(1);
    endtask
    task automatic t_reboot();
        reboot(8'hef, 3'h3);
        `CHK("reboot ab", 1'b1, use_loader_flash_o)
        press <= 3'h0;
        tick(3);
        `CHK("reboot held", 1'b1, use_loader_flash_o)
        reboot(8'hdf, 3'h4);
        `CHK("reboot c", 1'b1, use_loader_flash_o)
        reboot(8'hdf, 3'h3);
        `CHK("no reboot", 1'b0, use_loader_flash_o)
        press <= 3'h0;
        $display("reboot done");
    endtask
    task automatic final_report();
        $display("compared %0d failed %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        prog_mode_i <= 1;
        prog_erase_all_i <= 1;
        tick(2);
        prog_mode_i <= 0;
        prog_erase_all_i <= 0;
        tick(18);
        reset_i <= 0;
        t_boot();
        t_soft();
        t_update();
        t_prog();
        t_reboot();
        final_report();
    end
endmodule
`default_nettype wire

// file: verilog/boot_sel_pkg.sv
`default_nettype none
package boot_sel_pkg;
    typedef enum logic [3:0] {
        st_run     = 4'h1,
        st_restart = 4'h2,
        st_update  = 4'h4,
        st_idle    = 4'h8
    } boot_state_t;
endpackage
`default_nettype wire

// file: verilog/boot_sel_regs.svh
`ifndef BOOT_SEL_REGS_SVH
`define BOOT_SEL_REGS_SVH
`define OPT_LOCK_BIT      0
`define OPT_TABLE_BIT     1
`define OPT_STRAP_AB_BIT  4
`define OPT_STRAP_C_BIT   5
`define OPT_ERASED        8'hff
`define PCR_LOADER_IDLE   8'h03
`define PCR_RESTART       8'h83
`define PCR_UPDATE_IDLE   8'h01
`define PCR_RESET         8'h00
`define BANK_RESET        8'h00
`define RESTART_CYCLES    4'h4
`define RESTART_ZERO      4'h0
`define RESTART_ONE       4'h1
`endif

// file: verilog/boot_select.sv
`default_nettype none
`include "boot_sel_regs.svh"
// Notes on behaviour
// - default boot from main flash
// - bit4 low, straps a,b low: loader
// - bit5 low, strap c low: loader
// - 03 at idle: loader and restart
// - write 83: restart into main flash
// - 01 at idle: update, keep running
// - option bits only in programmer mode
// - programmed bits stay low until erase
// - lock bit low blocks programmer access except erase all
// - inhibit low: external reads stay external
// - internal reads reach all memory
// - inhibit high: no table read limit
module boot_select
    import boot_sel_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       reset_i,
    input  wire logic       strap_pin_a_i,
    input  wire logic       strap_pin_b_i,
    input  wire logic       strap_pin_c_i,
    input  wire logic       pcr_we_i,
    input  wire logic [7:0] pcr_wdata_i,
    input  wire logic       bank_we_i,
    input  wire logic [7:0] bank_wdata_i,
    input  wire logic       cpu_idle_i,
    input  wire logic       update_done_i,
    input  wire logic       fetch_internal_i,
    input  wire logic       table_read_i,
    input  wire logic       prog_mode_i,
    input  wire logic       prog_opt_we_i,
    input  wire logic       prog_opt_re_i,
    input  wire logic [7:0] prog_opt_wdata_i,
    input  wire logic       prog_flash_req_i,
    input  wire logic       prog_erase_all_i,
    output logic            use_loader_flash_o,
    output logic            cpu_restart_o,
    output logic            update_active_o,
    output logic [7:0]      pcr_rdata_o,
    output logic [7:0]      bank_select_o,
    output logic            table_internal_o,
    output logic            prog_flash_grant_o,
    output logic [7:0]      prog_opt_rdata_o,
    output logic            prog_refused_o
);
    // ------------------------------------------------------------
    // strap synchronisers
    // ------------------------------------------------------------
    logic [2:0] strap_meta;
    logic [2:0] strap_sync;
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            strap_meta <= 3'h7;
            strap_sync <= 3'h7;
        end else begin
            strap_meta <= {strap_pin_c_i, strap_pin_b_i, strap_pin_a_i};
            strap_sync <= strap_meta;
        end
    end
    // the flops run only after release, so straps are also sampled by a
    // free running capture that stays open while in reset
    logic [2:0] strap_hold_meta;
    logic [2:0] strap_hold;
    always_ff @(posedge clock_i) begin
        strap_hold_meta <= {strap_pin_c_i, strap_pin_b_i, strap_pin_a_i};
        strap_hold      <= strap_hold_meta;
    end

    // ------------------------------------------------------------
    // option bits
    // ------------------------------------------------------------
    option_store_if opt_bus ();
    option_store u_option_store (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .port    (opt_bus)
    );
    logic opt_access;
    assign opt_access = prog_mode_i & opt_bus.bits[`OPT_LOCK_BIT];
    assign opt_bus.prog_we   = opt_access & prog_opt_we_i;
    assign opt_bus.erase_all = prog_mode_i & prog_erase_all_i;
    assign opt_bus.prog_data = prog_opt_wdata_i;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        boot_state_t fsm;
        logic        first;
        logic        loader;
        logic [7:0]  pcr;
        logic [7:0]  bank;
        logic [3:0]  restart_cnt;
        logic [7:0]  opt_rdata;
        logic        refused;
        logic        grant;
    } top_state_t;
    top_state_t state;
    top_state_t next_state;

    logic strap_boot;
    always_comb begin
        strap_boot = 1'b0;
        if (!opt_bus.bits[`OPT_STRAP_AB_BIT] && !strap_hold[0] &&
            !strap_hold[1]) begin
            strap_boot = 1'b1;
        end
        if (!opt_bus.bits[`OPT_STRAP_C_BIT] && !strap_hold[2]) begin
            strap_boot = 1'b1;
        end
    end

    always_comb begin
        next_state         = state;
        next_state.first   = 1'b0;
        next_state.refused = 1'b0;
        next_state.grant   = 1'b0;
        if (state.first) begin
            next_state.loader = strap_boot;
        end
        if (bank_we_i) begin
            next_state.bank = bank_wdata_i;
        end
        if (pcr_we_i) begin
            next_state.pcr = pcr_wdata_i;
        end
        case (state.fsm)
            st_run: begin
                if (pcr_we_i && pcr_wdata_i == `PCR_RESTART) begin
                    next_state.loader      = 1'b0;
                    next_state.pcr         = `PCR_RESET;
                    next_state.restart_cnt = `RESTART_CYCLES;
                    next_state.fsm         = st_restart;
                end else if (cpu_idle_i && state.pcr == `PCR_LOADER_IDLE)
                begin
                    next_state.loader      = 1'b1;
                    next_state.restart_cnt = `RESTART_CYCLES;
                    next_state.fsm         = st_restart;
                end else if (cpu_idle_i && state.pcr == `PCR_UPDATE_IDLE)
                begin
                    next_state.fsm = st_update;
                end
            end
            st_restart: begin
                next_state.restart_cnt = state.restart_cnt - `RESTART_ONE;
                if (state.restart_cnt == `RESTART_ONE) begin
                    next_state.fsm = st_idle;
                end
            end
            st_update: begin
                if (update_done_i) begin
                    next_state.fsm = st_run;
                end
            end
            st_idle: begin
                next_state.fsm = st_run;
            end
            default: begin
                next_state.fsm = st_run;
            end
        endcase
        if (prog_flash_req_i || prog_opt_we_i || prog_opt_re_i) begin
            if (opt_access) begin
                next_state.grant = prog_flash_req_i;
            end else begin
                next_state.refused = 1'b1;
            end
        end
        if (opt_access && prog_opt_re_i) begin
            next_state.opt_rdata = opt_bus.bits;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state <= '{fsm: st_run, first: 1'b1, loader: 1'b0,
                       pcr: `PCR_RESET, bank: `BANK_RESET,
                       restart_cnt: `RESTART_ZERO, opt_rdata: 8'h00,
                       refused: 1'b0, grant: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic table_ok;
    always_comb begin
        table_ok = fetch_internal_i | opt_bus.bits[`OPT_TABLE_BIT];
    end
    assign table_internal_o   = table_read_i & table_ok;
    assign use_loader_flash_o = state.loader;
    assign cpu_restart_o      = (state.fsm == st_restart);
    assign update_active_o    = (state.fsm == st_update);
    assign pcr_rdata_o        = state.pcr;
    assign bank_select_o      = state.bank;
    assign prog_flash_grant_o = state.grant;
    assign prog_opt_rdata_o   = state.opt_rdata;
    assign prog_refused_o     = state.refused;
    logic unused_sync;
    assign unused_sync = ^strap_sync;
endmodule
`default_nettype wire

// file: verilog/option_store.sv
`default_nettype none
`include "boot_sel_regs.svh"
module option_store (
    input  wire logic      clock_i,
    input  wire logic      reset_i,
    option_store_if.owner  port
);
    typedef struct packed {
        logic [7:0] bits;
    } opt_state_t;
    opt_state_t state;
    opt_state_t next_state;
    always_comb begin
        next_state = state;
        if (port.erase_all) begin
            next_state.bits = `OPT_ERASED;
        end else if (port.prog_we) begin
            next_state.bits = state.bits & port.prog_data;
        end
    end
    // bits are non volatile: reset leaves them alone, only erase sets them
    always_ff @(posedge clock_i) begin
        state <= next_state;
    end
    assign port.bits = state.bits;
    logic unused_reset;
    assign unused_reset = reset_i;
endmodule
`default_nettype wire

// file: verilog/option_store_if.sv
`default_nettype none
interface option_store_if;
    logic       prog_we;
    logic       erase_all;
    logic [7:0] prog_data;
    logic [7:0] bits;
    modport owner (input prog_we, input erase_all, input prog_data,
                   output bits);
    modport user  (output prog_we, output erase_all, output prog_data,
                   input bits);
endinterface
`default_nettype wire
